// ---- hdl/eew_pkg.sv ----
`default_nettype none
package eew_pkg;
  // ****************************************
  // clock and cycle timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam real T_WIPE0_MS = 3.2;
  localparam real T_STORE0_MS = 2.2;
  localparam real T_WIPE1_MS = 3.7;
  localparam real T_STORE1_MS = 3.0;
  localparam int WIPE0_CYC = int'($ceil(T_WIPE0_MS * 1.0E6 / CLK_PERIOD_NS));
  localparam int STORE0_CYC = int'($ceil(T_STORE0_MS * 1.0E6 / CLK_PERIOD_NS));
  localparam int WIPE1_CYC = int'($ceil(T_WIPE1_MS * 1.0E6 / CLK_PERIOD_NS));
  localparam int STORE1_CYC = int'($ceil(T_STORE1_MS * 1.0E6 / CLK_PERIOD_NS));
  localparam int CNT_W = 19;

  // ****************************************
  // control register bit positions
  // ****************************************
  localparam int B_TSEL = 7;
  localparam int B_WPERM = 6;
  localparam int B_WGO = 5;
  localparam int B_MODE = 4;
  localparam int B_SPERM = 3;
  localparam int B_SGO = 2;
  localparam int B_FPERM = 1;
  localparam int B_FGO = 0;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int ADDR_W = 9;
  localparam int OFS_W = 4;
  localparam int PAGE_BYTES = 16;
  localparam logic [3:0] OFS_MAX = 4'hF;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [8:0] ADDR_RST = 9'h000;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] ARM_NONE = 2'h0;
  localparam logic [1:0] ARM_NEXT = 2'h1;
  localparam logic [1:0] ARM_FRESH = 2'h2;

  typedef enum logic [1:0]
  {
    EEW_IDLE = 2'h0,
    EEW_RUN  = 2'h1,
    EEW_FIN  = 2'h3
  } eew_state_e;

  typedef struct packed {
    eew_state_e       state;
    logic [7:0]       ctl;
    logic [8:0]       addr;
    logic [7:0]       dbyte;
    logic [15:0][7:0] pbuf;
    logic [15:0]      mask;
    logic             sat;
    logic [1:0]       arm_w;
    logic [1:0]       arm_s;
    logic             kind_wipe;
    logic [18:0]      cnt;
    logic             bsy_s1;
    logic             bsy_s2;
    logic             flag;
    logic             mf;
    logic             vec;
    logic             go;
    logic             pre_erase;
  } eew_state_s;
endpackage
`default_nettype wire

// ---- hdl/eew_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - mode high erases the tagged bytes of the 16-byte page
// - wipe permit fall or reset clears buffer
// - store permit fall clears buffer
// - page mode increments only low offset
// - offset stops at 0F, page fixed
// - data port write in page mode tags byte for erase
// - wipe go valid only next cycle after permit
// - array timer busy synchronised before completion
// - erase end clears go and permit in the same cycle
// - erased page locations become zero
// - byte write: permit then go next cycle
// - store go without permit does nothing
// - write end clears go and permit
// - byte write erases target byte first
// - page write loads buffer, offset advances
// - data port writes after saturation leave buffer and tags unchanged
// - end sets flags, vectors when all enabled and stack not full
// - service clears multi-function flag only
// - store permit cleared at power on
// - timing select picks cycle lengths
module eew_ctrl
#(
  parameter int WIPE0_CYC  = eew_pkg::WIPE0_CYC,
  parameter int STORE0_CYC = eew_pkg::STORE0_CYC,
  parameter int WIPE1_CYC  = eew_pkg::WIPE1_CYC,
  parameter int STORE1_CYC = eew_pkg::STORE1_CYC
)
(
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         ctl_wr,
  input  wire logic         addr_lo_wr,
  input  wire logic         addr_hi_wr,
  input  wire logic         byte_wr,
  input  wire logic [7:0]   wdata,
  input  wire logic         instr_tick,
  input  wire logic         nv_busy,
  input  wire logic         global_irq_enable,
  input  wire logic         nvm_irq_enable,
  input  wire logic         mf_irq_enable,
  input  wire logic         stack_full,
  input  wire logic         irq_ack,
  input  wire logic         flag_clr,
  output logic [7:0]        nvm_control_reg,
  output logic [7:0]        addr_lower_byte,
  output logic [7:0]        addr_upper_byte,
  output logic [7:0]        byte_port,
  output logic              nvm_irq_flag,
  output logic              mf_irq_flag,
  output logic              irq_vector,
  output logic              nv_go,
  output logic              nv_erase,
  output logic              nv_pre_erase,
  output logic              nv_page_mode,
  output logic [8:0]        nv_addr,
  output logic [15:0]       nv_mask,
  output logic [127:0]      nv_buf
);

  // ****************************************
  // reset release
  // ****************************************
  logic rst_s1;
  logic rst_q;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1 <= 1'b0;
      rst_q <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_q <= rst_s1;
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [18:0] cyc_for(input logic wipe, input logic tsel);
    int c;
    c = wipe ? (tsel ? WIPE1_CYC : WIPE0_CYC) : (tsel ? STORE1_CYC : STORE0_CYC);
    cyc_for = 19'(c - 1);
  endfunction

  function automatic logic [1:0] arm_step(input logic [1:0] a);
    arm_step = (a == eew_pkg::ARM_NONE) ? eew_pkg::ARM_NONE : 2'(a - 2'h1);
  endfunction

  // ****************************************
  // state
  // ****************************************
  eew_pkg::eew_state_s st;
  eew_pkg::eew_state_s next_st;
  logic [3:0] ofs;
  logic       idle;
  logic       wipe_ok;
  logic       store_ok;
  logic [7:0] c;

  assign ofs = st.addr[3:0];
  assign idle = (st.state == eew_pkg::EEW_IDLE);

  always_comb
  begin
    next_st = st;
    next_st.go = 1'b0;
    wipe_ok = 1'b0;
    store_ok = 1'b0;
    c = wdata;
    // array timer runs on its own clock; only the second stage is read
    next_st.bsy_s1 = nv_busy;
    next_st.bsy_s2 = st.bsy_s1;

    if (ctl_wr && idle)
    begin
      // a go bit counts only in the instruction cycle after its permit
      wipe_ok = c[eew_pkg::B_WGO] && c[eew_pkg::B_WPERM]
                && st.ctl[eew_pkg::B_WPERM] && st.arm_w == eew_pkg::ARM_NEXT;
      store_ok = c[eew_pkg::B_SGO] && c[eew_pkg::B_SPERM]
                 && st.ctl[eew_pkg::B_SPERM] && st.arm_s == eew_pkg::ARM_NEXT
                 && !wipe_ok;
      next_st.ctl = c;
      next_st.ctl[eew_pkg::B_WGO] = wipe_ok;
      next_st.ctl[eew_pkg::B_SGO] = store_ok;
      next_st.arm_w = (c[eew_pkg::B_WPERM] && !st.ctl[eew_pkg::B_WPERM]
                       && !c[eew_pkg::B_WGO]) ? eew_pkg::ARM_FRESH : eew_pkg::ARM_NONE;
      next_st.arm_s = (c[eew_pkg::B_SPERM] && !st.ctl[eew_pkg::B_SPERM]
                       && !c[eew_pkg::B_SGO]) ? eew_pkg::ARM_FRESH : eew_pkg::ARM_NONE;
      if (wipe_ok || store_ok)
      begin
        next_st.state = eew_pkg::EEW_RUN;
        next_st.kind_wipe = wipe_ok;
        next_st.cnt = cyc_for(wipe_ok, c[eew_pkg::B_TSEL]);
        next_st.go = 1'b1;
        next_st.pbuf = wipe_ok ? '0 : next_st.pbuf;
        // byte writes are preceded by an erase of the same byte
        next_st.pre_erase = store_ok && !c[eew_pkg::B_MODE];
        next_st.arm_w = eew_pkg::ARM_NONE;
        next_st.arm_s = eew_pkg::ARM_NONE;
      end
    end

    if (instr_tick)
    begin
      next_st.arm_w = arm_step(next_st.arm_w);
      next_st.arm_s = arm_step(next_st.arm_s);
    end

    if (addr_lo_wr && idle)
    begin
      next_st.addr[7:0] = wdata;
      next_st.sat = 1'b0;
    end
    if (addr_hi_wr && idle)
    begin
      next_st.addr[8] = wdata[0];
      next_st.sat = 1'b0;
    end

    if (byte_wr && idle)
    begin
      next_st.dbyte = wdata;
      // page mode: tag and load, then walk the offset up to 0F only
      if (st.ctl[eew_pkg::B_MODE] && !st.sat)
      begin
        next_st.pbuf[ofs] = wdata;
        next_st.mask[ofs] = 1'b1;
        if (ofs == eew_pkg::OFS_MAX)
        begin
          next_st.sat = 1'b1;
        end
        else
        begin
          next_st.addr[3:0] = 4'(ofs + 4'h1);
        end
      end
    end

    case (st.state)
      eew_pkg::EEW_IDLE:
      begin
      end
      eew_pkg::EEW_RUN:
      begin
        if (st.cnt != 19'h00000)
        begin
          next_st.cnt = 19'(st.cnt - 19'h00001);
        end
        else if (!st.bsy_s2)
        begin
          next_st.state = eew_pkg::EEW_FIN;
        end
      end
      eew_pkg::EEW_FIN:
      begin
        next_st.state = eew_pkg::EEW_IDLE;
        next_st.pre_erase = 1'b0;
        if (st.kind_wipe)
        begin
          next_st.ctl[eew_pkg::B_WGO] = 1'b0;
          next_st.ctl[eew_pkg::B_WPERM] = 1'b0;
        end
        else
        begin
          next_st.ctl[eew_pkg::B_SGO] = 1'b0;
          next_st.ctl[eew_pkg::B_SPERM] = 1'b0;
        end
      end
      default:
      begin
        next_st.state = eew_pkg::EEW_IDLE;
      end
    endcase

    // either permit falling empties the buffer, rising leaves it
    if ((st.ctl[eew_pkg::B_WPERM] && !next_st.ctl[eew_pkg::B_WPERM])
        || (st.ctl[eew_pkg::B_SPERM] && !next_st.ctl[eew_pkg::B_SPERM]))
    begin
      next_st.pbuf = '0;
      next_st.mask = 16'h0000;
      next_st.sat = 1'b0;
    end

    // clears first so an end in the same cycle still sets
    if (flag_clr)
    begin
      next_st.flag = 1'b0;
    end
    if (irq_ack)
    begin
      next_st.mf = 1'b0;
    end
    if (st.state == eew_pkg::EEW_FIN)
    begin
      next_st.flag = 1'b1;
      next_st.mf = 1'b1;
    end
    next_st.vec = next_st.mf && global_irq_enable && nvm_irq_enable
                  && mf_irq_enable && !stack_full;
  end

  // reset clears the whole control byte, store permit included
  always_ff @(posedge clk_sys or negedge rst_q)
  begin
    if (!rst_q)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign nvm_control_reg = st.ctl;
  assign addr_lower_byte = st.addr[7:0];
  assign addr_upper_byte = {7'h00, st.addr[8]};
  assign byte_port = st.dbyte;
  assign nvm_irq_flag = st.flag;
  assign mf_irq_flag = st.mf;
  assign irq_vector = st.vec;
  assign nv_go = st.go;
  assign nv_erase = st.kind_wipe;
  assign nv_pre_erase = st.pre_erase;
  assign nv_page_mode = st.ctl[eew_pkg::B_MODE];
  assign nv_addr = st.addr;
  assign nv_mask = st.mask;
  assign nv_buf = st.pbuf;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_q);

  sequence s_fin;
    st.state == eew_pkg::EEW_FIN;
  endsequence

  sequence s_page_wr;
    byte_wr && idle && st.ctl[eew_pkg::B_MODE] && !ctl_wr && !addr_lo_wr && !addr_hi_wr;
  endsequence

  chk_wipe_arm_order: assert property ($rose(st.ctl[eew_pkg::B_WGO]) |->
    $past(st.arm_w) == eew_pkg::ARM_NEXT && $past(st.ctl[eew_pkg::B_WPERM]))
    else $error("wipe go accepted without permit in previous cycle");

  chk_store_needs_permit: assert property ($rose(st.ctl[eew_pkg::B_SGO]) |->
    $past(st.ctl[eew_pkg::B_SPERM]) && nv_go)
    else $error("store go rose without store permit");

  chk_buf_clear_perm: assert property (($fell(st.ctl[eew_pkg::B_WPERM])
    || $fell(st.ctl[eew_pkg::B_SPERM])) |-> st.mask == 16'h0000 && st.pbuf == '0)
    else $error("page buffer not cleared on permit fall");

  chk_ofs_saturate: assert property ((s_page_wr and ofs == eew_pkg::OFS_MAX) |=>
    ofs == eew_pkg::OFS_MAX && st.addr[8:4] == $past(st.addr[8:4]) && st.sat)
    else $error("offset did not stop at page boundary");

  chk_ofs_step: assert property ((s_page_wr and (!st.sat && ofs != eew_pkg::OFS_MAX))
    |=> ofs == 4'($past(ofs) + 4'h1) && st.addr[8:4] == $past(st.addr[8:4]))
    else $error("page number changed during offset step");

  chk_sat_ignore: assert property ((s_page_wr and st.sat) |=>
    st.pbuf == $past(st.pbuf) && st.mask == $past(st.mask))
    else $error("buffer changed after offset saturated");

  chk_end_clears_go: assert property (s_fin |=> !st.ctl[eew_pkg::B_WGO]
    && !st.ctl[eew_pkg::B_SGO] && st.flag && st.mf && idle)
    else $error("cycle end did not clear go bits or raise flags");

  chk_go_pulse_once: assert property (nv_go |-> st.state == eew_pkg::EEW_RUN
    ##1 !nv_go [*3])
    else $error("array start pulse longer than one cycle");

  chk_pre_erase: assert property (nv_go && !nv_erase && !nv_page_mode |->
    nv_pre_erase)
    else $error("byte write started without erase first");

  chk_vector_gate: assert property (irq_vector |-> st.mf && $past(stack_full) == 1'b0)
    else $error("vector raised without flag or with full stack");

endmodule
`default_nettype wire

// ---- tb/eew_array_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// array timer stand-in
// ****************************************
module eew_array_model
#(
  parameter int BUSY_CYC = 4
)
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic nv_go,
  output logic      nv_busy
);
  int cnt;
  // busy moves 3 ns after the edge: the array timer is not phase locked to the core
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt = 0;
      nv_busy <= #3 1'b0;
    end
    else
    begin
      if (nv_go === 1'b1)
        cnt = BUSY_CYC;
      else if (cnt > 0)
        cnt = cnt - 1;
      nv_busy <= #3 (cnt > 0);
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_eew_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, a, b); end end
module tb_eew_ctrl;
  logic         clk_sys, rst_n, ctl_wr, addr_lo_wr, addr_hi_wr, byte_wr, instr_tick, nv_busy;
  logic         global_irq_enable, nvm_irq_enable, mf_irq_enable, stack_full, irq_ack, flag_clr;
  logic [7:0]   wdata, nvm_control_reg, addr_lower_byte, addr_upper_byte, byte_port;
  logic         nvm_irq_flag, mf_irq_flag, irq_vector, nv_go, nv_erase, nv_pre_erase;
  logic         nv_page_mode, g_er, g_pe, g_pm;
  logic [8:0]   nv_addr, g_addr;
  logic [15:0]  nv_mask, g_mask;
  logic [127:0] nv_buf;
  int           n_mismatch, compares, go_n, bad_zero;
  int           dur [2];

  eew_ctrl #(.WIPE0_CYC(20), .STORE0_CYC(15), .WIPE1_CYC(25), .STORE1_CYC(18)) dut
  (
    .clk_sys, .rst_n, .ctl_wr, .addr_lo_wr, .addr_hi_wr, .byte_wr, .wdata, .instr_tick,
    .nv_busy, .global_irq_enable, .nvm_irq_enable, .mf_irq_enable, .stack_full, .irq_ack,
    .flag_clr, .nvm_control_reg, .addr_lower_byte, .addr_upper_byte, .byte_port,
    .nvm_irq_flag, .mf_irq_flag, .irq_vector, .nv_go, .nv_erase, .nv_pre_erase,
    .nv_page_mode, .nv_addr, .nv_mask, .nv_buf
  );
  eew_array_model u_array (.clk_sys, .rst_n, .nv_go, .nv_busy);

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // the start pulse lasts one cycle, so latch what qualifies it
  always @(negedge clk_sys)
  begin
    if (nv_go === 1'b1)
    begin
      go_n++;
      g_er = nv_erase;
      g_pe = nv_pre_erase;
      g_pm = nv_page_mode;
      g_addr = nv_addr;
      g_mask = nv_mask;
    end
    if (nv_erase === 1'b1 && nvm_control_reg[5] === 1'b1 && nv_buf !== 128'h0)
      bad_zero++;
  end

  // strobe kinds: 0 ctl, 1 addr lo, 2 addr hi, 3 data port, 4 tick, 5 ack, 6 flag clear
  task automatic put(input int k, input logic [7:0] d);
    wdata = d;
    case (k)
      0: ctl_wr = 1'b1;
      1: addr_lo_wr = 1'b1;
      2: addr_hi_wr = 1'b1;
      3: byte_wr = 1'b1;
      4: instr_tick = 1'b1;
      5: irq_ack = 1'b1;
      default: flag_clr = 1'b1;
    endcase
    @(negedge clk_sys);
    {ctl_wr, addr_lo_wr, addr_hi_wr, byte_wr, instr_tick, irq_ack, flag_clr} = 7'h00;
    @(negedge clk_sys);
  endtask

  task automatic set_addr(input logic [8:0] a);
    put(2, {7'h00, a[8]});
    put(1, a[7:0]);
  endtask

  // interrupts masked only around the two activation writes
  task automatic act(input logic [7:0] p, input logic [7:0] g);
    global_irq_enable = 1'b0;
    put(0, p);
    put(4, 8'h00);
    put(0, p | g);
    global_irq_enable = 1'b1;
  endtask

  task automatic wait_done(output int n);
    n = 0;
    while ((nvm_control_reg[5] !== 1'b0 || nvm_control_reg[2] !== 1'b0) && n < 500)
    begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(n < 500, 1'b1)
  endtask

  task automatic t_reset();
    `CHK(nvm_control_reg, 8'h00)
    `CHK({addr_upper_byte, addr_lower_byte, byte_port}, 24'h000000)
    `CHK({nvm_irq_flag, mf_irq_flag, irq_vector}, 3'h0)
    `CHK(nv_mask, 16'h0000)
    $display("test reset done");
  endtask

  task automatic t_refuse();
    put(0, 8'h04);
    `CHK(nvm_control_reg, 8'h00)
    put(0, 8'h40);
    put(4, 8'h00);
    put(4, 8'h00);
    put(0, 8'h60);
    `CHK(nvm_control_reg, 8'h40)
    put(0, 8'h00);
    put(0, 8'h60);
    `CHK(nvm_control_reg, 8'h40)
    put(0, 8'h00);
    `CHK(go_n, 0)
    $display("test refuse done");
  endtask

  task automatic t_erase();
    int n;
    put(0, 8'h10);
    set_addr(9'h1ED);
    for (int i = 0; i < 4; i++)
      put(3, 8'hAA);
    `CHK({addr_upper_byte, addr_lower_byte}, 16'h01EF)
    `CHK(nv_mask, 16'hE000)
    act(8'hD0, 8'h20);
    wait_done(n);
    `CHK(n, 25)
    `CHK({go_n, g_er, g_pm, g_mask}, {32'd1, 2'h3, 16'hE000})
    `CHK(nvm_control_reg, 8'h90)
    `CHK({nvm_irq_flag, mf_irq_flag}, 2'h3)
    `CHK(bad_zero, 0)
    `CHK(nv_mask, 16'h0000)
    @(negedge clk_sys);
    `CHK(irq_vector, 1'b1)
    put(5, 8'h00);
    `CHK({nvm_irq_flag, mf_irq_flag}, 2'h2)
    put(6, 8'h00);
    `CHK(nvm_irq_flag, 1'b0)
    $display("test page erase done");
  endtask

  task automatic t_page_write();
    int n;
    stack_full = 1'b1;
    set_addr(9'h1E0);
    for (int i = 0; i < 17; i++)
      put(3, 8'h30 + 8'(i));
    `CHK({addr_lower_byte, nv_mask, byte_port}, 32'hEFFFFF40)
    `CHK({nv_buf[127:120], nv_buf[7:0]}, 16'h3F30)
    act(8'h18, 8'h04);
    wait_done(n);
    `CHK({go_n, g_er, g_pe, g_pm}, {32'd2, 3'h1})
    `CHK(nvm_control_reg, 8'h10)
    @(negedge clk_sys);
    `CHK({irq_vector, nvm_irq_flag}, 2'h1)
    put(5, 8'h00);
    put(6, 8'h00);
    stack_full = 1'b0;
    $display("test page write done");
  endtask

  task automatic t_buf_clear();
    logic [7:0] p [2] = '{8'h18, 8'h50};
    for (int i = 0; i < 2; i++)
    begin
      set_addr(9'h100 + 9'(i));
      put(3, 8'h77);
      put(0, p[i]);
      `CHK(nv_mask, 16'(1 << i))
      put(0, 8'h10);
      `CHK(nv_mask, 16'h0000)
    end
    $display("test buffer clear done");
  endtask

  task automatic t_byte_write();
    for (int t = 0; t < 2; t++)
    begin
      put(0, {t[0], 7'h00});
      set_addr(9'h0AB);
      put(3, 8'h5A);
      `CHK(addr_lower_byte, 8'hAB)
      act({t[0], 7'h08}, 8'h04);
      wait_done(dur[t]);
      `CHK({g_pe, g_er, g_addr, byte_port}, {2'h2, 9'h0AB, 8'h5A})
      `CHK(nvm_control_reg, {t[0], 7'h00})
      put(5, 8'h00);
      put(6, 8'h00);
    end
    `CHK(dur[1] - dur[0], 3)
    `CHK(go_n, 4)
    $display("test byte write done");
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    rst_n = 1'b0;
    {ctl_wr, addr_lo_wr, addr_hi_wr, byte_wr, instr_tick, irq_ack, flag_clr} = 7'h00;
    {global_irq_enable, nvm_irq_enable, mf_irq_enable, stack_full} = 4'hE;
    wdata = 8'h00;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_reset();
    t_refuse();
    t_erase();
    t_page_write();
    t_buf_clear();
    t_byte_write();
    summarize();
  end

  // whole sequence needs well under 2000 cycles
  initial
  begin
    #200000;
    n_mismatch++;
    $display("watchdog expired");
    summarize();
  end
endmodule
`default_nettype wire
